// ==== rtl/adc_fifo_host_interface.sv ====
// host side of a four-input pipelined converter: setup registers, soft reset,
// conversion timing and the 16-entry circular sample buffer with block signalling
// assumes bus, strobe and sample-clock pins asynchronous to ref_clk and the core delivering results on a valid/ready pair on ref_clk
`timescale 1ns/1ps
// What this block does
// - single-shot mode: strobe starts one conversion burst per selected input, internal oscillator.
// - free-running mode uses external sample clock; oscillator stays off.
// - writing 0x401 to interface_setup resets all setup and buffer state; staging fifo and pin filters keep theirs.
// - two ten-bit setup registers reached over the shared data bus.
// - setup fields sit at their documented bit positions.
// - value on lines zero to nine, register select on line ten, line eleven reserved.
// - line ten low selects converter_setup, high selects interface_setup.
// - buffer is circular, sixteen samples, old entries may be overwritten.
// - one sample stored per falling conversion clock edge, no host action.
// - host reads accepted asynchronously to the conversion clock.
// - read pointer is next to return; write pointer is last stored.
// - several inputs stored in fixed repeating channel order.
// - block_ready asserts when write pointer reaches trigger pointer.
// - depth code and input count select the block depth from the table.
// - full block read advances trigger pointer by block depth.
// - without reads, storing continues; trigger and read pointers hold.
// - overwriting unread data advances read and trigger pointers by input count.
// - interface_setup bits four and five pick level or pulse, low or high.
// - first block_ready comes eight clocks after reset: seven warm-up, then the first stored sample at trigger pointer zero.
// - converter_setup bit one picks free-running or single-shot operation.
module adc_fifo_host_interface
    import adc_host_pkg::*;
#(
    parameter int OSC_DIV = OSC_CYCLES,
    parameter int STAGE_WORDS = STAGE_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [DATA_W-1:0] bus_in,
    output logic [DATA_W-1:0] bus_out,
    output logic bus_oe_b,
    input wire logic cs_b,
    input wire logic rd_b,
    input wire logic wr_b,
    input wire logic single_shot_strobe,
    input wire logic sample_clock_in,
    input wire logic [DATA_W-1:0] result_data,
    input wire logic result_valid,
    output logic result_ready,
    output logic osc_run,
    output logic [1:0] scan_channel,
    output logic power_down,
    output logic block_ready
);
    typedef struct packed {
        logic [REG_W-1:0] cfg0;
        logic [REG_W-1:0] cfg1;
        logic [BUF_DEPTH-1:0][DATA_W-1:0] mem;
        logic [3:0] wr;
        logic [3:0] rd;
        logic [3:0] trig;
        logic [4:0] level;
        logic [4:0] left;
        logic pending;
        logic active;
        logic ovfl;
        logic [2:0] warm;
        logic [1:0] chan;
        logic bursting;
        logic [1:0] burst;
        logic [7:0] osc_cnt;
        logic sclk_prev;
        logic stb_prev;
        logic rd_prev;
        logic wr_prev;
        logic echo_sel;
        logic [DATA_W-1:0] dout;
    } host_s;

    localparam host_s ST_RESET = '{cfg0: CFG0_RESET, cfg1: CFG1_RESET, wr: WR_RESET, warm: WARMUP_TICKS,
                                   sclk_prev: 1'b0, stb_prev: 1'b1, rd_prev: 1'b1, wr_prev: 1'b1, default: '0};

    host_s q;
    host_s n;
    logic [DATA_W+4:0] pins_f;
    logic [DATA_W-1:0] bus_f;
    logic sclk_f, stb_f, cs_f, rd_f, wr_f;
    logic smp_valid;
    logic smp_take;
    logic [DATA_W-1:0] smp_data;
    logic cont, pulse, echo;
    logic [2:0] ch;
    logic [4:0] dep;
    logic osc_tick, tick, rd_evt, wr_ok, clear_now, store_now, fire_now;
    logic [3:0] next_wr;

    // bus, strobe and sample-clock pins through the three-stage filter; core result pins go straight to the staging buffer
    pin_filter #(
        .W(DATA_W + 5),
        .RESET_VAL({1'b0, 1'b1, 1'b1, 1'b1, 1'b1, {DATA_W{1'b0}}})
    ) u_pins (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in({sample_clock_in, single_shot_strobe, cs_b, rd_b, wr_b, bus_in}),
        .pin_out(pins_f)
    );
    assign {sclk_f, stb_f, cs_f, rd_f, wr_f, bus_f} = pins_f;

    // staging buffer; core stalls through result_ready when it fills
    stage_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(STAGE_WORDS)
    ) u_stage (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .in_data(result_data),
        .out_valid(smp_valid),
        .out_ready(smp_take),
        .out_data(smp_data)
    );

    // decoded setup fields
    // mode bit decode
    assign cont = !q.cfg0[MODE_BIT];
    assign pulse = q.cfg1[PULSE_BIT];
    assign echo = q.cfg1[ECHO_BIT];
    assign ch = {1'b0, q.cfg0[INPUT_PICK_HI:INPUT_PICK_LO]} + 3'h1;
    assign dep = depth_of(q.cfg1[DEPTH_HI:DEPTH_LO], q.cfg0[INPUT_PICK_HI:INPUT_PICK_LO]);

    // conversion tick: external falling edge or internal oscillator
    // external clock when free-running
    assign osc_tick = q.bursting && (q.osc_cnt == 8'(OSC_DIV - 1));
    assign tick = cont ? (q.sclk_prev && !sclk_f) : osc_tick;
    // host strobes taken as filtered pin edges
    assign rd_evt = q.rd_prev && !rd_f && !cs_f && !(!q.wr_prev && wr_f);
    // writes with reserved line set are dropped
    assign wr_ok = !q.wr_prev && wr_f && !cs_f && !bus_f[RSVD_BIT];
    assign clear_now = wr_ok && bus_f[SEL_BIT] && ((bus_f[REG_W-1:0] == RESET_CMD) || bus_f[CLEAR_BIT]);
    assign smp_take = tick && !clear_now;
    assign store_now = smp_take && (q.warm == 3'h0) && smp_valid;
    assign next_wr = q.wr + 4'h1;
    assign fire_now = store_now && n.pending && !q.pending;

    // next-state of the whole block
    always_comb begin
        n = q;
        if (wr_ok) begin
            // value on lines 0..9, select on line 10
            if (!bus_f[SEL_BIT]) begin
                n.cfg0 = bus_f[REG_W-1:0];
            end else if (bus_f[REG_W-1:0] == RESET_CMD) begin
                n = ST_RESET;
            end else begin
                n.cfg1 = bus_f[REG_W-1:0] & ~CMD_MASK;
                if (bus_f[CLEAR_BIT]) begin
                    n.wr = WR_RESET;
                    n.rd = 4'h0;
                    n.level = 5'h00;
                    n.pending = 1'b0;
                    n.active = 1'b0;
                    n.ovfl = 1'b0;
                    n.chan = 2'h0;
                    n.trig = 4'(depth_of(n.cfg1[DEPTH_HI:DEPTH_LO], n.cfg0[INPUT_PICK_HI:INPUT_PICK_LO]) - 5'h01);
                end
            end
        end
        // strobe starts a burst of one conversion per input
        if (cont) begin
            n.bursting = 1'b0;
        end else if (!q.bursting && q.stb_prev && !stb_f) begin
            n.bursting = 1'b1;
            n.burst = q.cfg0[INPUT_PICK_HI:INPUT_PICK_LO];
            n.osc_cnt = 8'h00;
        end else if (q.bursting) begin
            n.osc_cnt = osc_tick ? 8'h00 : q.osc_cnt + 8'h01;
            if (osc_tick) begin
                n.bursting = (q.burst != 2'h0);
                n.burst = q.burst - 2'h1;
            end
        end
        // host read: one sample, or register echo
        if (rd_evt) begin
            n.active = 1'b0;
            if (echo) begin
                n.dout = q.echo_sel ? {ECHO_TAG1, q.cfg1[REG_W-1:2], q.ovfl, 1'b0} : {ECHO_TAG0, q.cfg0};
                n.echo_sel = !q.echo_sel;
            end else if (q.level != 5'h00) begin
                n.dout = q.mem[q.rd] ^ {q.cfg1[FMT_BIT], {(DATA_W - 1){1'b0}}};
                n.rd = q.rd + 4'h1;
                n.level = q.level - 5'h01;
                if (q.pending) begin
                    // block done, trigger steps by depth
                    if (q.left <= 5'h01) begin
                        n.pending = 1'b0;
                        n.trig = q.trig + dep[3:0];
                    end else begin
                        n.left = q.left - 5'h01;
                    end
                end
            end
        end
        if (smp_take) begin
            // pulse form ends at the next conversion edge
            if (pulse) begin
                n.active = 1'b0;
            end
            if (q.warm != 3'h0) begin
                n.warm = q.warm - 3'h1;
            end else if (smp_valid) begin
                n.mem[next_wr] = smp_data;
                n.wr = next_wr;
                n.chan = (q.chan == 2'(ch - 3'h1)) ? 2'h0 : q.chan + 2'h1;
                if (n.level == LEVEL_FULL) begin
                    // overwrite shifts read and trigger by input count
                    n.rd = n.rd + 4'(ch);
                    n.trig = n.trig + 4'(ch);
                    n.level = LEVEL_FULL + 5'h01 - 5'(ch);
                    n.ovfl = 1'b1;
                end else begin
                    n.level = n.level + 5'h01;
                end
                if (!n.pending && next_wr == n.trig) begin
                    n.pending = 1'b1;
                    n.active = 1'b1;
                    n.left = dep;
                end
            end
        end
        n.sclk_prev = sclk_f;
        n.stb_prev = stb_f;
        n.rd_prev = rd_f;
        n.wr_prev = wr_f;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= ST_RESET;
        end else begin
            q <= n;
        end
    end

    // pin outputs
    // polarity select
    assign block_ready = q.cfg1[POL_BIT] ? q.active : !q.active;
    // data bus driven only during a selected read
    assign bus_oe_b = cs_f || rd_f;
    assign bus_out = q.dout;
    assign osc_run = q.bursting && !cont;
    assign scan_channel = q.chan;
    assign power_down = q.cfg0[POWER_DOWN_BIT];

    sequence s_host_read;
        rd_evt && !echo && (q.level != 5'h00);
    endsequence

    sequence s_block_end;
        s_host_read ##0 (q.pending && q.left == 5'h01);
    endsequence

    property p_osc_off;
        @(posedge ref_clk) disable iff (!rst_b) cont |=> (!q.bursting || !cont);
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator runs in free-running mode");

    property p_soft_reset;
        @(posedge ref_clk) disable iff (!rst_b)
            (wr_ok && bus_f[SEL_BIT] && bus_f[REG_W-1:0] == RESET_CMD) |=>
            (q.cfg0 == CFG0_RESET && q.wr == WR_RESET && q.level == 5'h00 && q.warm == WARMUP_TICKS);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("reset command did not reset state");

    property p_route0;
        @(posedge ref_clk) disable iff (!rst_b)
            (wr_ok && !bus_f[SEL_BIT]) |=> (q.cfg0 == $past(bus_f[REG_W-1:0]) && $stable(q.cfg1));
    endproperty
    a_route0: assert property (p_route0) else $error("line ten low did not reach converter_setup");

    property p_level_cap;
        @(posedge ref_clk) disable iff (!rst_b) q.level <= LEVEL_FULL;
    endproperty
    a_level_cap: assert property (p_level_cap) else $error("buffer holds more than sixteen");

    property p_read_step;
        @(posedge ref_clk) disable iff (!rst_b)
            (s_host_read ##0 !store_now) |=> (q.rd == $past(q.rd) + 4'h1 && q.dout[DATA_W-2:0] == $past(q.mem[q.rd][DATA_W-2:0]));
    endproperty
    a_read_step: assert property (p_read_step) else $error("read pointer did not step");

    property p_fire;
        @(posedge ref_clk) disable iff (!rst_b)
            (store_now && !q.pending && !rd_evt && next_wr == q.trig && q.level != LEVEL_FULL) |=>
            (q.pending && q.active && q.left == $past(dep));
    endproperty
    a_fire: assert property (p_fire) else $error("no block at trigger pointer");

    property p_trig_step;
        @(posedge ref_clk) disable iff (!rst_b)
            (s_block_end ##0 !store_now) |=> (q.trig == $past(q.trig) + $past(dep[3:0]) && !q.pending);
    endproperty
    a_trig_step: assert property (p_trig_step) else $error("trigger did not advance by depth");

    property p_hold;
        @(posedge ref_clk) disable iff (!rst_b)
            (store_now && !rd_evt && q.level != LEVEL_FULL) |=> ($stable(q.rd) && $stable(q.trig));
    endproperty
    a_hold: assert property (p_hold) else $error("pointers moved without a read");

    property p_wrap;
        @(posedge ref_clk) disable iff (!rst_b)
            (store_now && !rd_evt && q.level == LEVEL_FULL) |=>
            (q.rd == $past(q.rd) + 4'($past(ch)) && q.trig == $past(q.trig) + 4'($past(ch)) && q.ovfl);
    endproperty
    a_wrap: assert property (p_wrap) else $error("overwrite did not shift by input count");

    property p_pulse_end;
        @(posedge ref_clk) disable iff (!rst_b)
            (q.active && pulse && smp_take && !fire_now) |=> !q.active;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse outlived its conversion edge");

    property p_warm;
        @(posedge ref_clk) disable iff (!rst_b)
            (smp_take && q.warm != 3'h0) |=> ($stable(q.wr) && q.warm == $past(q.warm) - 3'h1);
    endproperty
    a_warm: assert property (p_warm) else $error("sample stored during warm-up");
endmodule : adc_fifo_host_interface

// ==== rtl/adc_host_pkg.sv ====
// constants, field positions and the block-depth table of the converter host port
// assumes a single 100 MHz clock domain in every module that imports it
package adc_host_pkg;
    localparam int DATA_W = 12;
    localparam int REG_W = 10;
    localparam int BUF_DEPTH = 16;
    localparam int STAGE_DEPTH = 16;
    // bus lines that carry the register select and the reserved bit during a write
    localparam int SEL_BIT = 10;
    localparam int RSVD_BIT = 11;
    // reset command value: reset bit alone, sent with select line ten high
    localparam logic [REG_W-1:0] RESET_CMD = 10'h001;
    // converter_setup fields
    localparam int MODE_BIT = 1;
    localparam int POWER_DOWN_BIT = 2;
    localparam int INPUT_PICK_LO = 3;
    localparam int INPUT_PICK_HI = 4;
    // interface_setup fields
    localparam int CLEAR_BIT = 1;
    localparam int DEPTH_LO = 2;
    localparam int DEPTH_HI = 3;
    localparam int PULSE_BIT = 4;
    localparam int POL_BIT = 5;
    localparam int FMT_BIT = 7;
    localparam int ECHO_BIT = 9;
    localparam logic [REG_W-1:0] CMD_MASK = 10'h003;
    localparam logic [REG_W-1:0] CFG0_RESET = 10'h000;
    localparam logic [REG_W-1:0] CFG1_RESET = 10'h030;
    localparam logic [1:0] ECHO_TAG0 = 2'h0;
    localparam logic [1:0] ECHO_TAG1 = 2'h1;
    // pointers and fill level
    localparam logic [3:0] WR_RESET = 4'hF;
    localparam logic [4:0] LEVEL_FULL = 5'h10;
    localparam logic [2:0] WARMUP_TICKS = 3'h7;
    // internal oscillator period, longest time so rounded down
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_PERIOD_NS = 170;
    localparam int OSC_CYCLES = (OSC_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : OSC_PERIOD_NS / CLK_PERIOD_NS;
    // block depth by [input count - 1][depth code]; the four-input reserved code gives 4
    localparam logic [0:3][0:3][4:0] DEPTH_TABLE = '{
        '{5'h01, 5'h04, 5'h08, 5'h0E},
        '{5'h02, 5'h04, 5'h08, 5'h0C},
        '{5'h03, 5'h06, 5'h09, 5'h0C},
        '{5'h04, 5'h08, 5'h0C, 5'h04}};

    // block depth from depth code and input-pick code
    function automatic logic [4:0] depth_of(input logic [1:0] code, input logic [1:0] pick);
        depth_of = DEPTH_TABLE[pick][code];
    endfunction : depth_of
endpackage : adc_host_pkg

// ==== rtl/pin_filter.sv ====
// three-stage input filter for pins from outside the clock domain
// assumes pins are asynchronous; a bit changes once stages two and three agree
`timescale 1ns/1ps
module pin_filter #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] held;
    } filt_s;

    filt_s q;
    filt_s d;

    // shift chain; held follows only where stage two and three agree
    always_comb begin
        d = q;
        d.s1 = pin_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.held = (q.s2 & q.s3) | (q.held & (q.s2 | q.s3));
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, held: RESET_VAL};
        end else begin
            q <= d;
        end
    end

    assign pin_out = q.held;
endmodule : pin_filter

// ==== rtl/stage_fifo.sv ====
// staging fifo between the converter core and the sample buffer
// assumes both sides on ref_clk; drain side may stall at will
`timescale 1ns/1ps
module stage_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fifo_s;

    fifo_s q;
    fifo_s d;
    logic full;
    logic empty;

    // full when pointers differ only in the wrap bit
    assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    assign empty = (q.wp == q.rp);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = q.mem[q.rp[AW-1:0]];

    // push and pop
    always_comb begin
        d = q;
        if (in_valid && !full) begin
            d.mem[q.wp[AW-1:0]] = in_data;
            d.wp = q.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            d.rp = q.rp + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : stage_fifo

// ==== verif/host_bus_model.sv ====
// host processor model on the shared parallel bus
// assumes the bench calls one task at a time, just after a clock edge
`timescale 1ns/1ps
module host_bus_model
    import adc_host_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [DATA_W-1:0] bus_out,
    input wire logic bus_oe_b,
    output logic [DATA_W-1:0] bus_in,
    output logic cs_b,
    output logic rd_b,
    output logic wr_b
);
    logic [DATA_W-1:0] drive_q = 12'h000;
    logic driving = 1'b0;
    // strobes idle high
    initial begin
        cs_b = 1'b1;
        rd_b = 1'b1;
        wr_b = 1'b1;
    end
    // wire level: device when enabled, else host value, inverted once released
    assign bus_in = !bus_oe_b ? bus_out : (driving ? drive_q : ~drive_q);
    task automatic write_reg(input logic sel, input logic [REG_W-1:0] val, input logic top);
        drive_q = {top, sel, val};
        driving = 1'b1;
        cs_b = 1'b0;
        wr_b = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        wr_b = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        cs_b = 1'b1;
        driving = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : write_reg
    // one read, data taken at a settled edge
    task automatic read_word(output logic [DATA_W-1:0] val);
        cs_b = 1'b0;
        rd_b = 1'b0;
        repeat (6) @(posedge ref_clk);
        val = bus_in; // off the wire, so the output enable must be low
        #1;
        rd_b = 1'b1;
        cs_b = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : read_word
endmodule : host_bus_model

// ==== verif/adc_fifo_host_interface_tb.sv ====
// self-checking bench: setup writes, block signalling, overflow, single shot, soft reset
// assumes host_bus_model on the bus and a counting core behind the staging fifo
`timescale 1ns/1ps
module adc_fifo_host_interface_tb;
    import adc_host_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic single_shot_strobe = 1'b1;
    logic sample_clock_in = 1'b1;
    logic result_valid = 1'b1;
    logic [DATA_W-1:0] result_data = 12'h000;
    logic [DATA_W-1:0] bus_in, bus_out, rdat, prev;
    logic bus_oe_b, cs_b, rd_b, wr_b, result_ready, osc_run, power_down, block_ready;
    logic [1:0] scan_channel, sc0;
    logic [4:0] d;
    int errors = 0;
    int comparisons = 0;
    logic [4:0] depth_tab [4][4] = '{'{5'h01, 5'h04, 5'h08, 5'h0E}, '{5'h02, 5'h04, 5'h08, 5'h0C},
        '{5'h03, 5'h06, 5'h09, 5'h0C}, '{5'h04, 5'h08, 5'h0C, 5'h00}};
    // free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;
    // counting core: next word after each accepted sample
    always @(posedge ref_clk) begin
        if (rst_b && result_valid && result_ready) begin
            result_data <= #1 result_data + 12'h001;
        end
    end
    adc_fifo_host_interface #(.OSC_DIV(2), .STAGE_WORDS(4)) dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .bus_in(bus_in), .bus_out(bus_out), .bus_oe_b(bus_oe_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
        .single_shot_strobe(single_shot_strobe), .sample_clock_in(sample_clock_in),
        .result_data(result_data), .result_valid(result_valid), .result_ready(result_ready),
        .osc_run(osc_run), .scan_channel(scan_channel), .power_down(power_down), .block_ready(block_ready));
    host_bus_model host (.ref_clk(ref_clk), .bus_out(bus_out), .bus_oe_b(bus_oe_b), .bus_in(bus_in),
        .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b));
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // n falling edges of the external sample clock
    task automatic tick(input int n);
        repeat (n) begin
            sample_clock_in = 1'b0;
            repeat (6) @(posedge ref_clk);
            #1 sample_clock_in = 1'b1;
            repeat (6) @(posedge ref_clk);
            #1;
        end
    endtask : tick
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    // bounded wait for the oscillator to reach a level
    task automatic wait_osc(input logic lvl);
        int w;
        for (w = 0; w < 100 && osc_run !== lvl; w++) begin
            @(posedge ref_clk);
            #1;
        end
        if (w == 100) begin
            errors++;
            $display("[ERR] %0t oscillator wait ran out", $time);
            give_verdict();
        end
    endtask : wait_osc
    initial begin
        int p, c, k;
        repeat (5) @(posedge ref_clk);
        #1;
        check(bus_out, 12'h000);
        check({5'h00, result_ready, bus_oe_b, block_ready, power_down, osc_run, scan_channel}, 12'h060);
        rst_b = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        host.write_reg(1'b1, 10'h020, 1'b0);
        tick(7);
        check(block_ready, 1'b0);
        tick(1);
        check(block_ready, 1'b1);
        check(osc_run, 1'b0);
        host.read_word(rdat);
        check(rdat, 12'h007);
        check(block_ready, 1'b0);
        host.write_reg(1'b0, 10'h004, 1'b1);
        check(power_down, 1'b0);
        host.write_reg(1'b0, 10'h004, 1'b0);
        check(power_down, 1'b1);
        // every input count and depth code, two blocks each, reserved pair skipped
        for (p = 0; p < 4; p++) begin
            for (c = 0; c < 4; c++) begin
                if (p == 3 && c == 3) continue;
                d = depth_tab[p][c];
                host.write_reg(1'b0, {5'h00, p[1:0], 3'h0}, 1'b0);
                host.write_reg(1'b1, {6'h02, c[1:0], 2'h2}, 1'b0);
                repeat (2) begin
                    sc0 = scan_channel;
                    tick(d - 5'h01);
                    check(block_ready, 1'b0);
                    tick(1);
                    check(block_ready, 1'b1);
                    check(12'((sc0 + d) % (p + 1)), scan_channel);
                    for (k = 0; k < d; k++) begin
                        host.read_word(rdat);
                        if (k > 0) check(rdat, prev + 12'h001);
                        prev = rdat;
                    end
                end
            end
        end
        host.write_reg(1'b0, 10'h000, 1'b0);
        host.write_reg(1'b1, 10'h222, 1'b0);
        tick(17);
        host.read_word(rdat);
        check(rdat, 12'h000);
        host.read_word(rdat);
        check(rdat, 12'h622);
        host.write_reg(1'b1, 10'h020, 1'b0);
        for (k = 0; k < 17; k++) begin
            host.read_word(rdat);
            if (k > 0) check(rdat, (k == 16) ? prev : prev + 12'h001);
            prev = rdat;
        end
        host.write_reg(1'b0, 10'h01A, 1'b0);
        host.write_reg(1'b1, 10'h022, 1'b0);
        single_shot_strobe = 1'b0;
        wait_osc(1'b1);
        single_shot_strobe = 1'b1;
        wait_osc(1'b0);
        repeat (3) @(posedge ref_clk);
        #1;
        check(block_ready, 1'b1);
        host.write_reg(1'b0, 10'h01E, 1'b0);
        check(power_down, 1'b1);
        host.write_reg(1'b1, 10'h001, 1'b0);
        check({block_ready, power_down, osc_run}, 12'h000);
        // pulse active low, depth eight, inverted sign bit
        host.write_reg(1'b1, 10'h09A, 1'b0);
        check(block_ready, 1'b1);
        tick(14);
        check(block_ready, 1'b1);
        tick(1);
        check(block_ready, 1'b0);
        tick(1);
        check(block_ready, 1'b1);
        host.read_word(rdat);
        check(rdat[11], 1'b1);
        give_verdict();
    end
endmodule : adc_fifo_host_interface_tb
